// ### core/lwd_watchdog.sv
/*
  Independent watchdog unit: control register on the special function
  register bus, timed disable sequence, lock, interval select and reset
  request. Assumes LFO_TICK pulses once per oscillator period, in step
  with SYS_CLK, and that the reset controller routes WDT_RESET_REQ to
  the core reset only, never to the external reset pin.
*/
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] counter overflow while active raises a reset request to the core
// [R2] after any reset the unit is active with interval 111b
// [R3] writing A5 enables the unit and restarts its timeout
// [R4] DE then AD within four system clocks disables; otherwise ignored
// [R5] writing FF locks out disabling until the next reset
// [R6] writing FF neither enables nor restarts the unit
// [R7] timeout is oscillator period times four to the power interval+3
// [R8] a write with bit 7 clear loads the interval from bits 2:0
// [R9] reads return interval in bits 2:0 and active flag in bit 4
// [R10] while active the low-frequency oscillator is forced on
// [R11] the watchdog reset leaves the external reset pin untouched
// [R12] software writes A5 often enough to avoid an overflow
// [R13] software masks interrupts around the two disable writes
// [R14] software that always wants the unit writes FF at start
// [R15] other codes with bit 7 set change nothing except closing an open disable window

module lwd_watchdog
  import lwd_pkg::*;
#(
  parameter int EXP_OFFSET = lwd_pkg::IV_EXP_OFFSET,
  parameter int CNT_W      = 2 * (int'(lwd_pkg::IV_MAX) + EXP_OFFSET)
) (
  input  wire logic              SYS_CLK,
  input  wire logic              ARST_N,
  input  wire logic              LFO_TICK,
  input  wire lwd_pkg::lwd_byte_t SFR_ADDR,
  input  wire logic              SFR_WR,
  input  wire lwd_pkg::lwd_byte_t SFR_WDATA,
  input  wire logic              SFR_RD,
  output lwd_pkg::lwd_byte_t     SFR_RDATA,
  output logic                   WDT_RESET_REQ,
  output logic                   LFO_FORCE_ON,
  output logic                   WDT_ACTIVE
);

  import lwd_pkg::*;

  logic             active_q;
  logic             lock_q;
  lwd_iv_t          iv_q;
  lwd_seq_e         seq_q;
  logic [2:0]       win_q;
  logic [2:0]       rst_cnt_q;
  logic             rst_req_q;
  logic             force_q;
  lwd_byte_t        rdata_q;

  logic             hit_wr;
  logic             hit_rd;
  logic             wr_reload;
  logic             wr_dis1;
  logic             wr_dis2;
  logic             wr_lock;
  logic             wr_iv;
  logic             dis_ok;
  logic             overflow;
  logic [CNT_W-1:0] limit_m1;

  // ticks minus one for the selected interval; a shift of CNT_W wraps
  // to zero so the subtraction yields the all-ones maximum
  function automatic logic [CNT_W-1:0] lwd_limit(input lwd_iv_t iv);
    logic [CNT_W-1:0] one;
    int               sh;
    one = {{(CNT_W-1){1'b0}}, 1'b1};
    sh  = 2 * (int'(iv) + EXP_OFFSET);
    return (one << sh) - one;
  endfunction

  assign limit_m1 = lwd_limit(iv_q); // R7

  // writes during the reset pulse are dropped: the core is held in reset
  assign hit_wr = SFR_WR && (SFR_ADDR == WDCTL_ADDR) && !rst_req_q;
  assign hit_rd = SFR_RD && (SFR_ADDR == WDCTL_ADDR);

  assign wr_iv     = hit_wr && !SFR_WDATA[CMD_BIT]; // R8
  assign wr_reload = hit_wr && (SFR_WDATA == CMD_RELOAD); // R3
  assign wr_dis1   = hit_wr && (SFR_WDATA == CMD_DISABLE_1);
  assign wr_dis2   = hit_wr && (SFR_WDATA == CMD_DISABLE_2);
  assign wr_lock   = hit_wr && (SFR_WDATA == CMD_LOCK); // R5
  // any bit-7 code other than those above matches no decode term R15

  // second write must land while the window is still open
  assign dis_ok = wr_dis2 && (seq_q == LWD_SEQ_ARMED) && (win_q != 3'h0)
                  && !lock_q; // R4

  lwd_lfo_counter #(
    .CNT_W    (CNT_W)
  ) u_counter (
    .clk      (SYS_CLK),
    .arst_n   (ARST_N),
    .tick     (LFO_TICK),
    .clear    (wr_reload || overflow), // R3
    .run      (active_q && !rst_req_q),
    .limit_m1 (limit_m1),
    .overflow (overflow)
  );

  // disable sequence: a first code opens a window of a few clocks
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      seq_q <= LWD_SEQ_IDLE;
      win_q <= 3'h0;
    end
    else if (overflow || wr_dis2 || (hit_wr && !wr_dis1))
    begin
      // any other write closes the window, so a pair counts only with no other code written between
      seq_q <= LWD_SEQ_IDLE;
      win_q <= 3'h0;
    end
    else if (wr_dis1)
    begin
      seq_q <= LWD_SEQ_ARMED;
      win_q <= DISABLE_WIN_CNT; // R4
    end
    else
    begin
      case (seq_q)
        LWD_SEQ_IDLE:
        begin
          win_q <= 3'h0;
        end
        LWD_SEQ_ARMED:
        begin
          if (win_q <= 3'h1)
          begin
            seq_q <= LWD_SEQ_IDLE;
            win_q <= 3'h0;
          end
          else
          begin
            win_q <= win_q - 3'h1;
          end
        end
        default:
        begin
          seq_q <= LWD_SEQ_IDLE;
          win_q <= 3'h0;
        end
      endcase
    end
  end

  // active flag: the own reset restores the power-on state
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      active_q <= ACTIVE_RESET; // R2
    end
    else if (overflow)
    begin
      active_q <= ACTIVE_RESET; // R2
    end
    else if (wr_reload)
    begin
      active_q <= 1'b1; // R3
    end
    else if (dis_ok)
    begin
      active_q <= 1'b0; // R4
    end
  end

  // lock is only ever cleared by a reset; the lock code leaves the
  // active flag and counter alone
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lock_q <= 1'b0;
    end
    else if (overflow)
    begin
      lock_q <= 1'b0;
    end
    else if (wr_lock)
    begin
      lock_q <= 1'b1; // R5 R6
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      iv_q <= IV_RESET; // R2
    end
    else if (overflow)
    begin
      iv_q <= IV_RESET; // R2
    end
    else if (wr_iv)
    begin
      iv_q <= SFR_WDATA[IV_MSB:0]; // R8
    end
  end

  // reset request pulse; it goes to the core reset, not the pin driver
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rst_cnt_q <= 3'h0;
      rst_req_q <= 1'b0;
    end
    else if (overflow)
    begin
      rst_cnt_q <= RST_PULSE_CNT; // R1
      rst_req_q <= 1'b1; // R1 R11
    end
    else if (rst_cnt_q != 3'h0)
    begin
      rst_cnt_q <= rst_cnt_q - 3'h1;
      rst_req_q <= (rst_cnt_q != 3'h1);
    end
    else
    begin
      rst_req_q <= 1'b0;
    end
  end

  // oscillator request follows the active flag one clock later
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      force_q <= ACTIVE_RESET;
    end
    else
    begin
      force_q <= active_q; // R10
    end
  end

  // read data is valid the clock after the strobe, zero otherwise
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rdata_q <= 8'h00;
    end
    else if (hit_rd)
    begin
      rdata_q <= 8'h00;
      rdata_q[IV_MSB:0] <= iv_q; // R9
      rdata_q[ACTIVE_BIT] <= active_q; // R9
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  assign SFR_RDATA     = rdata_q;
  assign WDT_RESET_REQ = rst_req_q;
  assign LFO_FORCE_ON  = force_q;
  assign WDT_ACTIVE    = force_q;

endmodule

`default_nettype wire

// ### core/lwd_pkg.sv
/*
  Shared constants for the low-frequency watchdog: control register
  address and layout, reset value, command codes and timing counts.
  Assumes an 8-bit special function register bus on the system clock.
*/
`default_nettype none

package lwd_pkg;

  typedef logic [7:0] lwd_byte_t;
  typedef logic [2:0] lwd_iv_t;

  // control register address on the special function register bus
  localparam lwd_byte_t WDCTL_ADDR       = 8'h97;
  localparam lwd_byte_t WDCTL_RESET      = 8'h17;

  // field positions
  localparam int        IV_MSB           = 2;
  localparam int        ACTIVE_BIT       = 4;
  localparam int        CMD_BIT          = 7;

  // reset state of the fields, and the largest interval
  localparam lwd_iv_t   IV_RESET         = 3'h7;
  localparam logic      ACTIVE_RESET     = 1'b1;
  localparam lwd_iv_t   IV_MAX           = 3'h7;

  // command codes written with the top bit set
  localparam lwd_byte_t CMD_RELOAD       = 8'hA5;
  localparam lwd_byte_t CMD_DISABLE_1    = 8'hDE;
  localparam lwd_byte_t CMD_DISABLE_2    = 8'hAD;
  localparam lwd_byte_t CMD_LOCK         = 8'hFF;

  // exponent offset of the interval: ticks = 4 ** (iv + offset)
  localparam int        IV_EXP_OFFSET    = 3;

  // second disable write must follow within this many system clocks
  localparam int        DISABLE_WIN_CLK  = 4;
  localparam logic [2:0] DISABLE_WIN_CNT = 3'(DISABLE_WIN_CLK);

  // length of the reset request pulse, in system clocks
  localparam int        RST_PULSE_CLK    = 4;
  localparam logic [2:0] RST_PULSE_CNT   = 3'(RST_PULSE_CLK);

  typedef enum logic [0:0] {
    LWD_SEQ_IDLE  = 1'b0,
    LWD_SEQ_ARMED = 1'b1
  } lwd_seq_e;

endpackage

`default_nettype wire

// ### core/lwd_lfo_counter.sv
/*
  Timeout counter of the watchdog, advanced by low-frequency oscillator
  ticks. Assumes the tick is a one-cycle pulse synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none

module lwd_lfo_counter #(
  parameter int CNT_W = 20
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             tick,
  input  wire logic             clear,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit_m1,
  output logic                  overflow
);

  logic [CNT_W-1:0] cnt_q;
  logic             ovf_q;

  // compare with >= so a shorter interval written mid-count still trips
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end
    else
    begin
      ovf_q <= 1'b0;
      if (clear || !run)
      begin
        cnt_q <= '0;
      end
      else if (tick)
      begin
        if (cnt_q >= limit_m1)
        begin
          cnt_q <= '0;
          ovf_q <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign overflow = ovf_q;

endmodule

`default_nettype wire

// ### tb/lwd_wdg_assertions.sv
/*
  Port checks for the watchdog unit.
  Assumes it is bound into lwd_watchdog and lwd_pkg is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module lwd_wdg_chk
  import lwd_pkg::*;
(
  input wire logic      SYS_CLK,
  input wire logic      ARST_N,
  input wire logic      LFO_TICK,
  input wire lwd_byte_t SFR_ADDR,
  input wire logic      SFR_WR,
  input wire lwd_byte_t SFR_WDATA,
  input wire logic      SFR_RD,
  input wire lwd_byte_t SFR_RDATA,
  input wire logic      WDT_RESET_REQ,
  input wire logic      LFO_FORCE_ON,
  input wire logic      WDT_ACTIVE
);
  logic wr;
  logic rd;
  // writes during the reset request are dropped, so they do not count
  assign wr = SFR_WR && SFR_ADDR == WDCTL_ADDR && !WDT_RESET_REQ;
  assign rd = SFR_RD && SFR_ADDR == WDCTL_ADDR;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);
  property p_idle;
    !rd |=> SFR_RDATA == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_act;
    rd |=> SFR_RDATA[ACTIVE_BIT] == LFO_FORCE_ON && SFR_RDATA[7:5] == 3'h0;
  endproperty
  a_act: assert property (p_act) else $error("active flag off");
  property p_a5;
    wr && SFR_WDATA == CMD_RELOAD |-> ##2 WDT_ACTIVE;
  endproperty
  a_a5: assert property (p_a5) else $error("reload not active");
  property p_dis;
    $fell(WDT_ACTIVE) |-> $past(wr && SFR_WDATA == CMD_DISABLE_2, 2);
  endproperty
  a_dis: assert property (p_dis) else $error("stray disable");
  property p_ff;
    wr && SFR_WDATA == CMD_LOCK ##1 !WDT_ACTIVE |=> !WDT_ACTIVE;
  endproperty
  a_ff: assert property (p_ff) else $error("lock enabled unit");
  property p_pulse;
    $rose(WDT_RESET_REQ) |-> WDT_RESET_REQ[*4] ##1 !WDT_RESET_REQ;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad req pulse");
  property p_tick;
    $rose(WDT_RESET_REQ) |-> $past(LFO_TICK) || $past(LFO_TICK, 2);
  endproperty
  a_tick: assert property (p_tick) else $error("req without tick");
  property p_dflt;
    $fell(WDT_RESET_REQ) |-> WDT_ACTIVE;
  endproperty
  a_dflt: assert property (p_dflt) else $error("not active");
endmodule

bind lwd_watchdog lwd_wdg_chk u_lwd_wdg_chk (.*);

`default_nettype wire

// ### tb/test_lfo_watchdog_timer.sv
/*
  Self-checking bench for the watchdog unit.
  Assumes lwd_pkg, the design and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module test_lfo_watchdog_timer;
  import lwd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_seen = 1'b0;
  lwd_byte_t   addr = WDCTL_ADDR;
  lwd_byte_t   wdata = 8'h00;
  lwd_byte_t   rdata;
  logic        req;
  logic        act;
  logic        lfo_on;
  logic [31:0] seed = 32'h0D73;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  lwd_byte_t   exp_q[$];
  // oscillator ticks of the shortest interval (field 0)
  localparam int TICKS = 4 ** IV_EXP_OFFSET;

  always #2.5 clk = ~clk;

  lwd_watchdog u_lwd_watchdog (
    .SYS_CLK       (clk),
    .ARST_N        (rst_n),
    .LFO_TICK      (tick),
    .SFR_ADDR      (addr),
    .SFR_WR        (wr),
    .SFR_WDATA     (wdata),
    .SFR_RD        (rd),
    .SFR_RDATA     (rdata),
    .WDT_RESET_REQ (req),
    .LFO_FORCE_ON  (lfo_on),
    .WDT_ACTIVE    (act)
  );

  task automatic chk(input string what, input lwd_byte_t seen,
                     input lwd_byte_t exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clk);
      {wr, rd, tick} = 3'b000;
    end
  endtask

  // wr is left high so two puts land on back-to-back edges
  task automatic put(input lwd_byte_t d);
    @(negedge clk);
    {wr, rd, tick} = 3'b100;
    wdata = d;
  endtask

  task automatic look(input lwd_byte_t e);
    @(negedge clk);
    {wr, rd, tick} = 3'b010;
    exp_q.push_back(e);
    idle(2);
  endtask

  task automatic pulse(input int n);
    repeat (n)
    begin
      @(negedge clk);
      {wr, rd, tick} = 3'b001;
      idle(1);
    end
  endtask

  always @(posedge clk) rd_seen <= rd && addr == WDCTL_ADDR;

  always @(negedge clk)
    if (rd_seen)
      chk("read data", rdata, exp_q.pop_front());

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      conclude;
    end
  end

  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    look(8'h17);
    chk("active output", {7'h00, act}, 8'h01);
    chk("oscillator request", {7'h00, lfo_on}, 8'h01);
    put(8'h85);
    idle(1);
    look(8'h17);
    addr = 8'h98;
    put(8'h00);
    idle(1);
    addr = WDCTL_ADDR;
    look(8'h17);
    repeat (4)
    begin
      seed = xs(seed);
      put({1'b0, seed[6:0]});
      idle(1);
      look({5'h02, seed[2:0]});
    end
    put(8'h02);
    put(CMD_DISABLE_1);
    idle(4);
    put(CMD_DISABLE_2);
    idle(1);
    look(8'h12);
    put(CMD_DISABLE_1);
    idle(3);
    put(CMD_DISABLE_2);
    idle(1);
    look(8'h02);
    put(CMD_LOCK);
    idle(1);
    look(8'h02);
    put(CMD_RELOAD);
    idle(1);
    look(8'h12);
    put(CMD_DISABLE_1);
    put(CMD_DISABLE_2);
    idle(1);
    look(8'h12);
    // half an interval before the reload would overflow without it
    put(8'h00);
    idle(1);
    pulse(TICKS / 2);
    put(CMD_RELOAD);
    idle(1);
    pulse(TICKS - 1);
    idle(4);
    chk("reset request", {7'h00, req}, 8'h00);
    pulse(1);
    chk("reset request", {7'h00, req}, 8'h00);
    @(negedge clk);
    chk("reset request", {7'h00, req}, 8'h01);
    idle(8);
    look(8'h17);
    put(CMD_DISABLE_1);
    put(CMD_DISABLE_2);
    idle(1);
    look(8'h07);
    chk("active output", {7'h00, act}, 8'h00);
    chk("oscillator request", {7'h00, lfo_on}, 8'h00);
    conclude;
  end
endmodule

`default_nettype wire
